// File: logic/swl_pkg.sv
package swl_pkg;

  // ----------------------------------------------------------------
  // clock and timing, times in ns
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  // shortest low that counts as a break
  localparam int T_BREAK_MIN_NS = 100000;
  // host low shorter than this decodes as one, longer as zero
  localparam int T_BIT_THRESH_NS = 50000;
  // device pause after the command before the first read slot
  localparam int T_TURN_NS = 100000;
  localparam int T_DEV_SLOT_NS = 200000;
  localparam int T_DEV_ONE_LOW_NS = 40000;
  localparam int T_DEV_ZERO_LOW_NS = 120000;

  // ----------------------------------------------------------------
  // widths and fields
  // ----------------------------------------------------------------
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int CODE_W = 7;
  localparam int DIR_BIT = 7;
  localparam logic DIR_WRITE = 1'h1;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CMD = 3'h1,
    ST_TURN = 3'h3,
    ST_RDAT = 3'h2,
    ST_WDAT = 3'h5
  } swl_state_t;

  typedef enum logic [1:0] {
    MODE_OTHER = 2'h0,
    MODE_ALERT = 2'h1,
    MODE_DEDIC = 2'h2
  } swl_mode_t;

  // least time: round up
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // longest time: round down
  function automatic int cyc_dn(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

endpackage

// File: logic/swl_slave.sv
`timescale 1ns/100ps

// How it works
// - both ends only pull the wire low; a pullup returns it high
// - every byte goes least significant bit first
// - command bits 0 to 6 are the code, bit 7 the direction
// - direction picks capturing 8 write bits or sending 8 read bits
// - device is slave only; it drives only inside a read data phase
// - data phase is 8 slots by the writer with its own timing
// - one byte per transaction, no code increment
// - link sits on the alert pin or on the dedicated pin
// - configured-interface swap moves to the configured interface now
// - single-wire swap moves to single-wire on the alert pin now
module swl_slave #(
  parameter logic [swl_pkg::CNT_W-1:0] BRK_CYC =
    16'(swl_pkg::cyc_up(swl_pkg::T_BREAK_MIN_NS)),
  parameter logic [swl_pkg::CNT_W-1:0] BIT_CYC =
    16'(swl_pkg::cyc_up(swl_pkg::T_BIT_THRESH_NS)),
  parameter logic [swl_pkg::CNT_W-1:0] TURN_CYC =
    16'(swl_pkg::cyc_up(swl_pkg::T_TURN_NS)),
  parameter logic [swl_pkg::CNT_W-1:0] SLOT_CYC =
    16'(swl_pkg::cyc_up(swl_pkg::T_DEV_SLOT_NS)),
  parameter logic [swl_pkg::CNT_W-1:0] DW1_CYC =
    16'(swl_pkg::cyc_dn(swl_pkg::T_DEV_ONE_LOW_NS)),
  parameter logic [swl_pkg::CNT_W-1:0] DW0_CYC =
    16'(swl_pkg::cyc_up(swl_pkg::T_DEV_ZERO_LOW_NS)),
  parameter swl_pkg::swl_mode_t RESET_MODE = swl_pkg::MODE_OTHER
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire swl_pkg::swl_mode_t cfg_mode,
  input wire logic swap_cfg,
  input wire logic swap_single,
  input wire logic alert_i,
  output logic alert_o,
  output logic alert_oe,
  input wire logic wire_i,
  output logic wire_o,
  output logic wire_oe,
  input wire logic [swl_pkg::BYTE_W-1:0] rd_data,
  output logic rd_req,
  output logic wr_stb,
  output logic [swl_pkg::CODE_W-1:0] cmd_code,
  output logic cmd_wr,
  output logic [swl_pkg::BYTE_W-1:0] wr_data,
  output swl_pkg::swl_mode_t if_mode
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  swl_pkg::swl_state_t st_r, st_nxt;
  swl_pkg::swl_mode_t mode_r, mode_nxt;
  logic line_r, line_nxt, prev_r;
  logic [swl_pkg::CNT_W-1:0] low_r, low_nxt, slot_r, slot_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic [swl_pkg::BYTE_W-1:0] sh_r, sh_nxt, out_sh_r, out_sh_nxt;
  logic [swl_pkg::BYTE_W-1:0] wr_data_r, wr_data_nxt;
  logic [swl_pkg::CODE_W-1:0] code_r, code_nxt;
  logic cmd_wr_r, cmd_wr_nxt, rd_req_r, rd_req_nxt, wr_stb_r, wr_stb_nxt;
  logic alert_oe_r, alert_oe_nxt, wire_oe_r, wire_oe_nxt, drive;
  logic rise, brk, bitv, out_lvl_r;
  logic [swl_pkg::BYTE_W-1:0] new_byte;

  // low width the device holds for one of its own bits
  function automatic logic [swl_pkg::CNT_W-1:0] low_len(input logic b);
    return b ? DW1_CYC : DW0_CYC;
  endfunction

  // end of every low pulse seen on the selected pin
  assign rise = line_r & ~prev_r;
  assign brk = rise && (low_r >= BRK_CYC);
  assign bitv = (low_r < BIT_CYC);
  assign new_byte = {bitv, sh_r[swl_pkg::BYTE_W-1:1]};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    mode_nxt = mode_r;
    if (swap_single) begin
      mode_nxt = swl_pkg::MODE_ALERT;
    end else if (swap_cfg) begin
      mode_nxt = cfg_mode;
    end
    case (mode_r)
      swl_pkg::MODE_ALERT: line_nxt = alert_i;
      swl_pkg::MODE_DEDIC: line_nxt = wire_i;
      default: line_nxt = 1'h1;
    endcase
    low_nxt = line_r ? 16'h0000 :
      ((low_r == 16'hFFFF) ? low_r : low_r + 16'h0001);
    st_nxt = st_r;
    slot_nxt = slot_r;
    idx_nxt = idx_r;
    sh_nxt = sh_r;
    out_sh_nxt = out_sh_r;
    wr_data_nxt = wr_data_r;
    code_nxt = code_r;
    cmd_wr_nxt = cmd_wr_r;
    rd_req_nxt = 1'h0;
    wr_stb_nxt = 1'h0;
    drive = 1'h0;
    case (st_r)
      swl_pkg::ST_IDLE: begin
        // device never starts anything; it only waits for a break
        st_nxt = swl_pkg::ST_IDLE;
      end
      swl_pkg::ST_CMD: begin
        if (rise) begin
          sh_nxt = new_byte;
          idx_nxt = 3'(idx_r + 3'h1);
          if (idx_r == swl_pkg::LAST_BIT) begin
            code_nxt = new_byte[swl_pkg::CODE_W-1:0];
            cmd_wr_nxt = new_byte[swl_pkg::DIR_BIT];
            idx_nxt = 3'h0;
            slot_nxt = 16'h0000;
            if (new_byte[swl_pkg::DIR_BIT] == swl_pkg::DIR_WRITE) begin
              st_nxt = swl_pkg::ST_WDAT;
            end else begin
              st_nxt = swl_pkg::ST_TURN;
              rd_req_nxt = 1'h1;
            end
          end
        end
      end
      swl_pkg::ST_WDAT: begin
        if (rise) begin
          sh_nxt = new_byte;
          idx_nxt = 3'(idx_r + 3'h1);
          if (idx_r == swl_pkg::LAST_BIT) begin
            wr_data_nxt = new_byte;
            wr_stb_nxt = 1'h1;
            st_nxt = swl_pkg::ST_IDLE;
          end
        end
      end
      swl_pkg::ST_TURN: begin
        // internal logic has the whole pause to present rd_data
        slot_nxt = slot_r + 16'h0001;
        if (slot_r == TURN_CYC - 16'h0001) begin
          st_nxt = swl_pkg::ST_RDAT;
          slot_nxt = 16'h0000;
          out_sh_nxt = rd_data;
          drive = 1'h1;
        end
      end
      swl_pkg::ST_RDAT: begin
        if (slot_r == SLOT_CYC - 16'h0001) begin
          slot_nxt = 16'h0000;
          out_sh_nxt = out_sh_r >> 1;
          idx_nxt = 3'(idx_r + 3'h1);
          drive = 1'h1;
          if (idx_r == swl_pkg::LAST_BIT) begin
            st_nxt = swl_pkg::ST_IDLE;
            drive = 1'h0;
          end
        end else begin
          slot_nxt = slot_r + 16'h0001;
          drive = (slot_nxt < low_len(out_sh_r[0]));
        end
      end
      default: st_nxt = swl_pkg::ST_IDLE;
    endcase
    // a break wins over any partial byte
    if (brk) begin
      st_nxt = swl_pkg::ST_CMD;
      idx_nxt = 3'h0;
      drive = 1'h0;
    end
    // a pin swap drops the transaction rather than finish on a dead pin
    if (mode_nxt != mode_r) begin
      st_nxt = swl_pkg::ST_IDLE;
      drive = 1'h0;
    end
    alert_oe_nxt = drive && (mode_nxt == swl_pkg::MODE_ALERT);
    wire_oe_nxt = drive && (mode_nxt == swl_pkg::MODE_DEDIC);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st_r <= swl_pkg::ST_IDLE;
      mode_r <= RESET_MODE;
      line_r <= 1'h1;
      prev_r <= 1'h1;
      low_r <= 16'h0000;
      slot_r <= 16'h0000;
      idx_r <= 3'h0;
      sh_r <= 8'h00;
      out_sh_r <= 8'h00;
      wr_data_r <= 8'h00;
      code_r <= 7'h00;
      cmd_wr_r <= 1'h0;
      rd_req_r <= 1'h0;
      wr_stb_r <= 1'h0;
      alert_oe_r <= 1'h0;
      wire_oe_r <= 1'h0;
      out_lvl_r <= 1'h0;
    end else begin
      st_r <= st_nxt;
      mode_r <= mode_nxt;
      line_r <= line_nxt;
      prev_r <= line_r;
      low_r <= low_nxt;
      slot_r <= slot_nxt;
      idx_r <= idx_nxt;
      sh_r <= sh_nxt;
      out_sh_r <= out_sh_nxt;
      wr_data_r <= wr_data_nxt;
      code_r <= code_nxt;
      cmd_wr_r <= cmd_wr_nxt;
      rd_req_r <= rd_req_nxt;
      wr_stb_r <= wr_stb_nxt;
      alert_oe_r <= alert_oe_nxt;
      wire_oe_r <= wire_oe_nxt;
      out_lvl_r <= 1'h0;
    end
  end

  // open drain: the level is always low, only the enable moves
  assign alert_o = out_lvl_r;
  assign wire_o = out_lvl_r;
  assign alert_oe = alert_oe_r;
  assign wire_oe = wire_oe_r;
  assign rd_req = rd_req_r;
  assign wr_stb = wr_stb_r;
  assign cmd_code = code_r;
  assign cmd_wr = cmd_wr_r;
  assign wr_data = wr_data_r;
  assign if_mode = mode_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  one_pin_a: assert property (!(alert_oe_r && wire_oe_r))
    else $error("both link pins driven");
  slave_drv_a: assert property (
    (alert_oe_r || wire_oe_r) |-> st_r == swl_pkg::ST_RDAT)
    else $error("device drives outside read data");
  swap_sw_a: assert property (
    swap_single |=> mode_r == swl_pkg::MODE_ALERT && !wire_oe_r)
    else $error("single-wire swap not on alert pin");
  swap_cfg_a: assert property (
    (swap_cfg && !swap_single) |=> mode_r == $past(cfg_mode))
    else $error("configured swap not taken");
  brk_restart_a: assert property (
    (brk && mode_nxt == mode_r) |=> st_r == swl_pkg::ST_CMD && idx_r == 3'h0)
    else $error("break did not restart command");
  bit_one_a: assert property (
    (st_r == swl_pkg::ST_CMD && rise && !brk && bitv && !swap_cfg &&
     !swap_single) |=> sh_r[7])
    else $error("short low not decoded as one");
  dir_rd_a: assert property (rd_req_r |-> !cmd_wr_r)
    else $error("read request with write direction");
  one_byte_a: assert property (
    wr_stb_r |-> cmd_wr_r && st_r == swl_pkg::ST_IDLE ##1 !wr_stb_r)
    else $error("write strobe not single byte end");
  lsb_load_a: assert property (
    (st_r == swl_pkg::ST_TURN && st_nxt == swl_pkg::ST_RDAT) |=>
    out_sh_r == $past(rd_data) && (alert_oe_r || wire_oe_r))
    else $error("read byte not loaded at first slot");

  wr_done_c: cover property (wr_stb_r);
  rd_start_c: cover property (rd_req_r ##[1:2] st_r == swl_pkg::ST_TURN);
  rd_end_c: cover property (st_r == swl_pkg::ST_RDAT && idx_r == 3'h7
    ##1 st_r == swl_pkg::ST_IDLE);
  swap_c: cover property (swap_cfg && cfg_mode == swl_pkg::MODE_DEDIC);

endmodule

// File: verif/swl_host.sv
`timescale 1ns/100ps

// ----------------------------------------
// host model: pulls the wire low only
// ----------------------------------------
module swl_host #(
  parameter int BRK = 40
) (
  input wire logic clk_sys,
  input wire logic line,
  output logic pull
);
  initial pull = 1'b0;

  task automatic brk();
    pull = 1'b1;
    repeat (BRK + 4) @(negedge clk_sys);
    pull = 1'b0;
    repeat (12) @(negedge clk_sys);
  endtask

  // short low for one, long low for zero, then release
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      pull = 1'b1;
      repeat (b[i] ? 4 : 20) @(negedge clk_sys);
      pull = 1'b0;
      repeat (b[i] ? 26 : 10) @(negedge clk_sys);
    end
  endtask

  // bounded waits so a silent device cannot hang the host
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int w;
    b = 8'h00;
    ok = 1'b1;
    for (int i = 0; i < 8; i++) begin
      // first bit waits out the device turnaround pause
      w = 0;
      while (line === 1'b1 && w < 6000) begin
        @(negedge clk_sys);
        w++;
      end
      if (w >= 6000) ok = 1'b0;
      w = 0;
      while (line !== 1'b1 && w < 300) begin
        @(negedge clk_sys);
        w++;
      end
      b[i] = (w < 10);
    end
  endtask
endmodule

// File: verif/swl_slave_tb_top.sv
`timescale 1ns/100ps

module swl_slave_tb_top;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  swl_pkg::swl_mode_t cfg_mode = swl_pkg::MODE_OTHER;
  logic swap_cfg = 1'b0;
  logic swap_single = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic alert_o, alert_oe, wire_o, wire_oe, rd_req, wr_stb, cmd_wr;
  logic [6:0] cmd_code;
  logic [7:0] wr_data;
  swl_pkg::swl_mode_t if_mode;
  logic pull, sel_dedic = 1'b0, alert_ln, wire_ln, host_ln;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  int n_errors = 0, cmp_count = 0, cyc = 0;

  always #10 clk_sys = ~clk_sys;

  // ----------------------------------------
  // open-drain wires with pullup
  // ----------------------------------------
  // a driven pin only goes low if the device level is low as well
  assign alert_ln = ~(pull & ~sel_dedic) & ~(alert_oe & ~alert_o);
  assign wire_ln = ~(pull & sel_dedic) & ~(wire_oe & ~wire_o);
  assign host_ln = sel_dedic ? wire_ln : alert_ln;

  swl_host host_u (.clk_sys(clk_sys), .line(host_ln), .pull(pull));

  // turnaround left at its default so the full pause is exercised
  swl_slave #(.BRK_CYC(16'h0028), .BIT_CYC(16'h000A),
    .SLOT_CYC(16'h001E), .DW1_CYC(16'h0005),
    .DW0_CYC(16'h000F)) dut_u (.clk_sys(clk_sys), .rstn(rstn),
    .cfg_mode(cfg_mode), .swap_cfg(swap_cfg), .swap_single(swap_single),
    .alert_i(alert_ln), .alert_o(alert_o), .alert_oe(alert_oe),
    .wire_i(wire_ln), .wire_o(wire_o), .wire_oe(wire_oe),
    .rd_data(rd_data), .rd_req(rd_req), .wr_stb(wr_stb),
    .cmd_code(cmd_code), .cmd_wr(cmd_wr), .wr_data(wr_data),
    .if_mode(if_mode));

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_errors++;
      $display("ERROR %0t: seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------
  // watcher: each strobe takes the oldest note
  // ----------------------------------------
  always @(negedge clk_sys) begin
    if (rstn && (rd_req === 1'b1 || wr_stb === 1'b1)) begin
      if (exp_q.size() == 0) check(16'h0001, 16'h0000);
      else begin
        e = exp_q.pop_front();
        check(16'(wr_stb), 16'(e[15]));
        check(16'({cmd_wr, cmd_code}), 16'(e[15:8]));
        if (e[15]) check(16'(wr_data), 16'(e[7:0]));
      end
    end
  end

  always @(posedge clk_sys) begin
    cyc++;
    // up to six reads with a 5000-cycle turnaround each, plus writes
    if (cyc >= 45000) begin
      n_errors++;
      $display("ERROR %0t: run too long", $time);
      summarize();
    end
  end

  task automatic xfer(input logic wr, input logic [6:0] code,
                      input logic [7:0] d, input logic note);
    logic [7:0] got;
    logic ok;
    if (note) exp_q.push_back({wr, code, d});
    rd_data = d;
    host_u.brk();
    host_u.send_bits({wr, code}, 8);
    if (wr) host_u.send_bits(d, 8);
    else if (note) begin
      host_u.recv_byte(got, ok);
      check(16'(ok), 16'h0001);
      check(16'(got), 16'(d));
    end
    repeat (40) @(negedge clk_sys);
  endtask

  task automatic swap(input logic sc, input logic ss,
                      input swl_pkg::swl_mode_t m,
                      input swl_pkg::swl_mode_t want);
    cfg_mode = m;
    swap_cfg = sc;
    swap_single = ss;
    @(negedge clk_sys);
    swap_cfg = 1'b0;
    swap_single = 1'b0;
    @(negedge clk_sys);
    check(16'(if_mode), 16'(want));
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(74));
    repeat (2) @(negedge clk_sys);
    rstn = 1'b1;
    @(negedge clk_sys);
    check(16'({alert_o, wire_o, alert_oe, wire_oe, if_mode}), 16'h0000);
    // link off: pins ignored, no strobe expected
    xfer(1'b1, 7'h2A, 8'h3C, 1'b0);
    swap(1'b0, 1'b1, swl_pkg::MODE_DEDIC, swl_pkg::MODE_ALERT);
    xfer(1'b1, 7'h7F, 8'h00, 1'b1);
    xfer(1'b0, 7'h00, 8'hFF, 1'b1);
    for (int i = 0; i < 4; i++) begin
      xfer(1'($urandom), 7'($urandom), 8'($urandom), 1'b1);
    end
    // partial command cut short by a fresh break
    host_u.brk();
    host_u.send_bits(8'h5A, 3);
    xfer(1'b1, 7'h15, 8'hA6, 1'b1);
    // both pulses: single-wire swap wins
    swap(1'b1, 1'b1, swl_pkg::MODE_DEDIC, swl_pkg::MODE_ALERT);
    swap(1'b1, 1'b0, swl_pkg::MODE_DEDIC, swl_pkg::MODE_DEDIC);
    sel_dedic = 1'b1;
    xfer(1'b1, 7'h33, 8'($urandom), 1'b1);
    xfer(1'b0, 7'h41, 8'($urandom), 1'b1);
    swap(1'b1, 1'b0, swl_pkg::MODE_OTHER, swl_pkg::MODE_OTHER);
    xfer(1'b1, 7'h01, 8'h81, 1'b0);
    check(16'(exp_q.size()), 16'h0000);
    check(16'({alert_o, wire_o}), 16'h0000);
    summarize();
  end
endmodule
